// ==== common/link_regs_pkg.sv ====
// constants for the link width, clock select and fault log registers
// Behaviour
// - receive physical width in bits 2:0
// - width codes 8,16,32,2,4 bits, unconnected, reserved
// - bit 3 shows receive dword credit capability
// - transmit physical width in bits 6:4
// - bit 7 shows transmit dword credit capability
// - receive used width loaded from negotiation
// - used widths reach link after reset/stop
// - receive dword credit enable, warm reset applies
// - transmit used width loaded from negotiation
// - lanes beyond used width are shut off
// - transmit dword credit enable, cold clears
// - revision holds minor 4:0, major 7:5
// - four-bit code selects transmit clock rate
// - clock code applies on warm reset/stop
// - code is ceiling unless synchronous mode
// - 200 MHz code always supported
// - protocol fault log bit 4
// - overflow fault log bit 5
// - end-of-chain fault log bit 6
// - timeout select bit 7, 1 ms or 1 s
// - capability mask bit per supported code
// - mask bit 0 always one, 15 vendor
package link_regs_pkg;
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int CTL_SHORT_MS  = 1;
	localparam int CTL_LONG_S    = 1;
	localparam int CTL_SHORT_CYC =
		CTL_SHORT_MS * 1000000 / CLK_PERIOD_NS;
	localparam int CTL_LONG_CYC  =
		CTL_LONG_S * 1000000000 / CLK_PERIOD_NS;

	// register indices, byte address is four times
	localparam logic [5:0] IDX_LINK_CFG = 6'h06;
	localparam logic [5:0] IDX_REV      = 6'h08;
	localparam logic [5:0] IDX_FRQ_ERR  = 6'h09;
	localparam logic [5:0] IDX_RATES    = 6'h0A;
	localparam logic [5:0] IDX_ACTIVE   = 6'h0B;
	localparam logic [7:0] ADDR_LINK_CFG = {IDX_LINK_CFG, 2'h0};
	localparam logic [7:0] ADDR_REV      = {IDX_REV, 2'h0};
	localparam logic [7:0] ADDR_FRQ_ERR  = {IDX_FRQ_ERR, 2'h0};
	localparam logic [7:0] ADDR_RATES    = {IDX_RATES, 2'h0};
	localparam logic [7:0] ADDR_ACTIVE   = {IDX_ACTIVE, 2'h0};

	// width codes
	localparam logic [2:0] WIDTH_8    = 3'h0;
	localparam logic [2:0] WIDTH_16   = 3'h1;
	localparam logic [2:0] WIDTH_32   = 3'h3;
	localparam logic [2:0] WIDTH_2    = 3'h4;
	localparam logic [2:0] WIDTH_4    = 3'h5;
	localparam logic [2:0] WIDTH_NONE = 3'h7;

	// width ranks, narrow to wide
	localparam logic [2:0] RANK_NONE = 3'h0;
	localparam logic [2:0] RANK_2    = 3'h1;
	localparam logic [2:0] RANK_4    = 3'h2;
	localparam logic [2:0] RANK_8    = 3'h3;
	localparam logic [2:0] RANK_16   = 3'h4;
	localparam logic [2:0] RANK_32   = 3'h5;
	localparam logic [2:0] RANK_BAD  = 3'h7;

	// byte lane enables per width
	localparam logic [3:0] LANES_NONE = 4'h0;
	localparam logic [3:0] LANES_ONE  = 4'h1;
	localparam logic [3:0] LANES_TWO  = 4'h3;
	localparam logic [3:0] LANES_ALL  = 4'hF;

	// configuration word fields
	localparam int CFG_RX_PHYS = 0;
	localparam int CFG_RX_CAP  = 3;
	localparam int CFG_TX_PHYS = 4;
	localparam int CFG_TX_CAP  = 7;
	localparam int CFG_RX_USED = 8;
	localparam int CFG_RX_ON   = 11;
	localparam int CFG_TX_USED = 12;
	localparam int CFG_TX_ON   = 15;
	// revision fields
	localparam int REV_MINOR = 0;
	localparam int REV_MAJOR = 5;
	// clock code and fault log fields
	localparam int FRQ_CODE  = 0;
	localparam int ERR_PROTO = 4;
	localparam int ERR_OVF   = 5;
	localparam int ERR_EOC   = 6;
	localparam int ERR_TMO   = 7;
	// active settings word fields
	localparam int ACT_RX    = 0;
	localparam int ACT_TX    = 4;
	localparam int ACT_RX_ON = 8;
	localparam int ACT_TX_ON = 9;
	localparam int ACT_CEIL  = 10;
	localparam int ACT_CODE  = 12;
	localparam int ACT_LANES = 16;
	localparam int ACT_LOAD  = 20;
	// pstrb lanes
	localparam int LANE_LO = 0;
	localparam int LANE_HI = 1;

	// clock codes and capability mask
	localparam logic [3:0]  CODE_200    = 4'h0;
	localparam logic [3:0]  CODE_VENDOR = 4'hF;
	localparam logic [15:0] RATE_BASE   = 16'h0001;
	localparam logic [15:0] RATE_VENDOR = 16'h8000;
endpackage

// ==== design/link_width_freq_error_regs.sv ====
// link width, clock select and fault log register bank
`timescale 1ns/1ps
`default_nettype none
module link_width_freq_error_regs #(
	parameter logic [2:0]  RX_PHYS     = link_regs_pkg::WIDTH_16,
	parameter logic [2:0]  TX_PHYS     = link_regs_pkg::WIDTH_16,
	parameter logic        RX_CAP      = 1'b1,
	parameter logic        TX_CAP      = 1'b1,
	parameter logic [2:0]  REV_MAJ     = 3'h1,
	parameter logic [4:0]  REV_MIN     = 5'h00,
	parameter logic [15:0] RATE_CAP    = 16'h0023,
	parameter logic        VENDOR_RATE = 1'b0,
	parameter logic        PROTO_CHK   = 1'b1,
	parameter logic        OVF_CHK     = 1'b1,
	parameter logic        EOC_CHK     = 1'b1,
	parameter int unsigned CTL_SHORT   =
		link_regs_pkg::CTL_SHORT_CYC,
	parameter int unsigned CTL_LONG    =
		link_regs_pkg::CTL_LONG_CYC
)(
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        warm_rst_n,
	input  wire logic        link_stop_request_n,
	input  wire logic        link_control_strobe,
	input  wire logic        ctl_watch_en,
	input  wire logic        sync_clock_mode,
	input  wire logic        neg_done,
	input  wire logic [2:0]  neg_rx_width,
	input  wire logic [2:0]  neg_tx_width,
	input  wire logic        proto_err_evt,
	input  wire logic        overflow_evt,
	input  wire logic        tx_issue_evt,
	input  wire logic        end_of_chain,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic [2:0]       rx_width_active,
	output logic [2:0]       tx_width_active,
	output logic             rx_dword_credit_active,
	output logic             tx_dword_credit_active,
	output logic [3:0]       tx_clock_code_active,
	output logic             clock_code_is_ceiling,
	output logic [3:0]       tx_lane_off
);
	// supported clock codes, base rate forced
	localparam logic [15:0] RATES =
		(RATE_CAP & ~link_regs_pkg::RATE_VENDOR)
		| link_regs_pkg::RATE_BASE
		| (VENDOR_RATE ? link_regs_pkg::RATE_VENDOR
			: 16'h0000);

	typedef struct packed {
		logic        warm_s1;
		logic        warm_s2;
		logic        stop_s1;
		logic        stop_s2;
		logic        ctl_s1;
		logic        ctl_s2;
		logic [2:0]  rx_used;
		logic [2:0]  tx_used;
		logic        rx_on;
		logic        tx_on;
		logic [3:0]  code;
		logic        err_proto;
		logic        err_ovf;
		logic        err_eoc;
		logic        tmo_sel;
		logic        loaded;
		logic [31:0] ctl_cnt;
		logic [2:0]  act_rx;
		logic [2:0]  act_tx;
		logic        act_rx_on;
		logic        act_tx_on;
		logic [3:0]  act_code;
		logic        act_ceil;
		logic [3:0]  lane_off;
		logic [31:0] prdata;
	} state_t;

	state_t q;
	state_t nxt;
	logic   unmapped;

	// order of width codes, bad for reserved
	function automatic logic [2:0] width_rank(
		input logic [2:0] c
	);
		case (c)
			link_regs_pkg::WIDTH_NONE:
				width_rank = link_regs_pkg::RANK_NONE;
			link_regs_pkg::WIDTH_2:
				width_rank = link_regs_pkg::RANK_2;
			link_regs_pkg::WIDTH_4:
				width_rank = link_regs_pkg::RANK_4;
			link_regs_pkg::WIDTH_8:
				width_rank = link_regs_pkg::RANK_8;
			link_regs_pkg::WIDTH_16:
				width_rank = link_regs_pkg::RANK_16;
			link_regs_pkg::WIDTH_32:
				width_rank = link_regs_pkg::RANK_32;
			default:
				width_rank = link_regs_pkg::RANK_BAD;
		endcase
	endfunction

	// legal used width: known code, not above physical
	function automatic logic width_ok(
		input logic [2:0] c,
		input logic [2:0] phys
	);
		logic [2:0] r;
		r = width_rank(c);
		width_ok = (r != link_regs_pkg::RANK_BAD)
			&& (r <= width_rank(phys));
	endfunction

	// byte lanes carried by a width
	function automatic logic [3:0] lane_mask(
		input logic [2:0] c
	);
		case (width_rank(c))
			link_regs_pkg::RANK_2,
			link_regs_pkg::RANK_4,
			link_regs_pkg::RANK_8:
				lane_mask = link_regs_pkg::LANES_ONE;
			link_regs_pkg::RANK_16:
				lane_mask = link_regs_pkg::LANES_TWO;
			link_regs_pkg::RANK_32:
				lane_mask = link_regs_pkg::LANES_ALL;
			default:
				lane_mask = link_regs_pkg::LANES_NONE;
		endcase
	endfunction

	// next state: bus, events, apply points, reset
	always_comb
	begin
		logic [31:0] rd;
		logic [31:0] limit;
		logic        wr;
		logic        warm;
		logic        apply;
		logic [2:0]  w;
		logic [3:0]  c;
		// per-cycle helpers for writes and the watchdog
		logic        cfg_we;
		logic        frq_we;
		logic        strobe_low;
		logic        strobe_fire;
		rd = 32'h0000_0000;
		limit = 32'h0000_0000;
		wr = 1'b0;
		warm = q.warm_s2;
		apply = q.warm_s2 | q.stop_s2;
		w = 3'h0;
		c = 4'h0;
		cfg_we = 1'b0;
		frq_we = 1'b0;
		strobe_low = 1'b0;
		strobe_fire = 1'b0;
		nxt = q;
		unmapped = 1'b0;

		// two-stage pin synchronisers
		nxt.warm_s1 = ~warm_rst_n;
		nxt.warm_s2 = q.warm_s1;
		nxt.stop_s1 = ~link_stop_request_n;
		nxt.stop_s2 = q.stop_s1;
		nxt.ctl_s1 = link_control_strobe;
		nxt.ctl_s2 = q.ctl_s1;

		// read decode
		case (paddr)
			// fixed capability fields, then pending settings
			link_regs_pkg::ADDR_LINK_CFG:
			begin
				rd[link_regs_pkg::CFG_RX_PHYS +: 3] =
					RX_PHYS;
				rd[link_regs_pkg::CFG_RX_CAP] =
					RX_CAP;
				rd[link_regs_pkg::CFG_TX_PHYS +: 3] =
					TX_PHYS;
				rd[link_regs_pkg::CFG_TX_CAP] =
					TX_CAP;
				rd[link_regs_pkg::CFG_RX_USED +: 3] = q.rx_used;
				rd[link_regs_pkg::CFG_RX_ON] = q.rx_on;
				rd[link_regs_pkg::CFG_TX_USED +: 3] = q.tx_used;
				rd[link_regs_pkg::CFG_TX_ON] = q.tx_on;
			end
			// fixed protocol revision
			link_regs_pkg::ADDR_REV:
			begin
				rd[link_regs_pkg::REV_MINOR +: 5] = REV_MIN;
				rd[link_regs_pkg::REV_MAJOR +: 3] =
					REV_MAJ;
			end
			// pending clock code and fault logs
			link_regs_pkg::ADDR_FRQ_ERR:
			begin
				rd[link_regs_pkg::FRQ_CODE +: 4] = q.code;
				rd[link_regs_pkg::ERR_PROTO] = q.err_proto;
				rd[link_regs_pkg::ERR_OVF] = q.err_ovf;
				rd[link_regs_pkg::ERR_EOC] = q.err_eoc;
				rd[link_regs_pkg::ERR_TMO] = q.tmo_sel;
			end
			// supported clock codes
			link_regs_pkg::ADDR_RATES:
				rd[15:0] = RATES;
			// settings in force on the link
			link_regs_pkg::ADDR_ACTIVE:
			begin
				rd[link_regs_pkg::ACT_RX +: 3] = q.act_rx;
				rd[link_regs_pkg::ACT_TX +: 3] = q.act_tx;
				rd[link_regs_pkg::ACT_RX_ON] = q.act_rx_on;
				rd[link_regs_pkg::ACT_TX_ON] = q.act_tx_on;
				rd[link_regs_pkg::ACT_CEIL] = q.act_ceil;
				rd[link_regs_pkg::ACT_CODE +: 4] = q.act_code;
				rd[link_regs_pkg::ACT_LANES +: 4] = ~q.lane_off;
				rd[link_regs_pkg::ACT_LOAD] = q.loaded;
			end
			// holes and misaligned addresses
			default:
				unmapped = 1'b1;
		endcase

		// read data captured in the setup cycle
		if (psel && !penable)
			nxt.prdata = rd;

		// writes land in the access cycle
		wr = psel && penable && pwrite && !unmapped;
		cfg_we = wr && paddr == link_regs_pkg::ADDR_LINK_CFG
			&& pstrb[link_regs_pkg::LANE_HI];
		frq_we = wr && paddr == link_regs_pkg::ADDR_FRQ_ERR
			&& pstrb[link_regs_pkg::LANE_LO];

		// software writes to the pending settings
		if (cfg_we)
		begin
			// illegal widths leave the field as it was
			w = pwdata[link_regs_pkg::CFG_RX_USED +: 3];
			if (width_ok(w, RX_PHYS))
				nxt.rx_used = w;
			w = pwdata[link_regs_pkg::CFG_TX_USED +: 3];
			if (width_ok(w, TX_PHYS))
				nxt.tx_used = w;
			// enables stick at zero without capability
			nxt.rx_on = pwdata[link_regs_pkg::CFG_RX_ON]
				& RX_CAP;
			nxt.tx_on = pwdata[link_regs_pkg::CFG_TX_ON]
				& TX_CAP;
		end

		// clock code and fault log byte
		if (frq_we)
		begin
			c = pwdata[link_regs_pkg::FRQ_CODE +: 4];
			if (RATES[c])
				nxt.code = c;
			// a one clears a log bit, a zero keeps it
			if (pwdata[link_regs_pkg::ERR_PROTO])
				nxt.err_proto = 1'b0;
			if (pwdata[link_regs_pkg::ERR_OVF])
				nxt.err_ovf = 1'b0;
			if (pwdata[link_regs_pkg::ERR_EOC])
				nxt.err_eoc = 1'b0;
			nxt.tmo_sel = pwdata[link_regs_pkg::ERR_TMO];
		end

		// control strobe low-time watchdog
		limit = q.tmo_sel ? CTL_LONG : CTL_SHORT;
		strobe_low = !q.ctl_s2 && ctl_watch_en && !warm;
		// a shorter limit chosen mid-count fires once, unless the count already equals it
		strobe_fire = strobe_low && (q.ctl_cnt > limit
			|| q.ctl_cnt == limit - 32'h0000_0001);
		if (strobe_low && q.ctl_cnt < limit)
			nxt.ctl_cnt = q.ctl_cnt + 32'h0000_0001;
		else if (strobe_low)
			nxt.ctl_cnt = limit;
		else
			nxt.ctl_cnt = 32'h0000_0000;

		// fault events set, winning over a clear
		if ((proto_err_evt || strobe_fire) && PROTO_CHK)
			nxt.err_proto = 1'b1;
		if (overflow_evt && OVF_CHK)
			nxt.err_ovf = 1'b1;
		if (tx_issue_evt && end_of_chain && EOC_CHK)
			nxt.err_eoc = 1'b1;

		// warm reset clears the timeout select
		if (warm)
			nxt.tmo_sel = 1'b0;

		// first negotiation result after cold reset
		if (neg_done && !q.loaded)
		begin
			nxt.loaded = 1'b1;
			// a code wider than physical is not loaded
			if (width_ok(neg_rx_width, RX_PHYS))
			begin
				nxt.rx_used = neg_rx_width;
				nxt.act_rx = neg_rx_width;
			end
			if (width_ok(neg_tx_width, TX_PHYS))
			begin
				nxt.tx_used = neg_tx_width;
				nxt.act_tx = neg_tx_width;
				nxt.lane_off = ~lane_mask(neg_tx_width);
			end
		end

		// pending settings reach the link
		if (apply)
		begin
			nxt.act_rx = q.rx_used;
			nxt.act_tx = q.tx_used;
			nxt.lane_off = ~lane_mask(q.tx_used);
			nxt.act_code = q.code;
			nxt.act_ceil = !sync_clock_mode;
		end
		// dword modes change on warm reset only
		if (warm)
		begin
			nxt.act_rx_on = q.rx_on;
			nxt.act_tx_on = q.tx_on;
		end

		// cold reset
		if (rst)
		begin
			nxt = '0;
			// active settings start at the physical widths
			nxt.rx_used = RX_PHYS;
			nxt.tx_used = TX_PHYS;
			nxt.act_rx = RX_PHYS;
			nxt.act_tx = TX_PHYS;
			nxt.code = link_regs_pkg::CODE_200;
			nxt.act_code = link_regs_pkg::CODE_200;
			nxt.act_ceil = 1'b1;
			nxt.lane_off = ~lane_mask(TX_PHYS);
			// strobe idles high: no false low time after reset
			nxt.ctl_s1 = 1'b1;
			nxt.ctl_s2 = 1'b1;
		end
	end

	// state register
	always_ff @(posedge core_clk)
	begin
		q <= nxt;
	end

	// bus answers in the access cycle
	assign pready  = psel & penable;
	assign pslverr = psel & penable & unmapped;
	assign prdata  = q.prdata;

	// applied settings toward the link
	assign rx_width_active        = q.act_rx;
	assign tx_width_active        = q.act_tx;
	assign rx_dword_credit_active = q.act_rx_on;
	assign tx_dword_credit_active = q.act_tx_on;
	assign tx_clock_code_active   = q.act_code;
	assign clock_code_is_ceiling  = q.act_ceil;
	assign tx_lane_off            = q.lane_off;
endmodule
`default_nettype wire

// ==== sim/link_regs_asserts.sv ====
// checker for the link register bank ports
`timescale 1ns/1ps
`default_nettype none
module link_regs_asserts #(
	parameter logic [2:0]  REV_MAJ     = 3'h1,
	parameter logic [4:0]  REV_MIN     = 5'h00,
	parameter logic [15:0] RATE_CAP    = 16'h0023,
	parameter logic        VENDOR_RATE = 1'b0
)(
	input wire logic        core_clk,
	input wire logic        rst,
	input wire logic        warm_rst_n,
	input wire logic        link_stop_request_n,
	input wire logic        sync_clock_mode,
	input wire logic        neg_done,
	input wire logic [7:0]  paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [2:0]  rx_width_active,
	input wire logic [2:0]  tx_width_active,
	input wire logic        rx_dword_credit_active,
	input wire logic        tx_dword_credit_active,
	input wire logic [3:0]  tx_clock_code_active,
	input wire logic        clock_code_is_ceiling,
	input wire logic [3:0]  tx_lane_off
);
	logic       acc;
	logic       rdg;
	logic       mapped;
	logic [3:0] lanes_on;
	logic [2:0] quiet_r;
	logic [2:0] quiet_nxt;

	// access decode and lanes in use
	assign acc = psel && penable;
	assign rdg = acc && !pwrite;
	assign mapped = paddr inside {8'h18, 8'h20, 8'h24, 8'h28, 8'h2C};
	assign lanes_on = tx_width_active == 3'h7 ? 4'h0 :
		tx_width_active == 3'h1 ? 4'h3 :
		tx_width_active == 3'h3 ? 4'hF : 4'h1;
	// counts cycles with no source of new settings
	assign quiet_nxt = (rst || !warm_rst_n || !link_stop_request_n
		|| neg_done) ? 3'h0 : quiet_r + {2'h0, quiet_r != 3'h7};
	always_ff @(posedge core_clk)
		quiet_r <= quiet_nxt;

	default clocking dc @(posedge core_clk);
	endclocking
	default disable iff (rst);

	chk_ready_on: assert property (acc |-> pready)
		else $error("pready low in access");
	chk_ready_idle: assert property (!acc |-> !pready && !pslverr)
		else $error("pready or pslverr outside access");
	chk_slverr_map: assert property (acc |-> pslverr == !mapped)
		else $error("pslverr off the address map");
	chk_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
		else $error("prdata moved without setup");
	chk_rev_value: assert property (rdg && paddr == 8'h20
		|-> prdata == {24'h0, REV_MAJ, REV_MIN})
		else $error("revision read wrong");
	chk_rate_mask: assert property (rdg && paddr == 8'h28
		|-> prdata == {16'h0, VENDOR_RATE, RATE_CAP[14:1], 1'b1})
		else $error("rate mask read wrong");
	chk_lane_shut: assert property (tx_lane_off == ~lanes_on)
		else $error("lane shut-off disagrees with width");
	chk_active_quiet: assert property (quiet_r > 3'h4 |->
		$stable({rx_width_active, tx_width_active, tx_clock_code_active,
		rx_dword_credit_active, tx_dword_credit_active}))
		else $error("active setting moved while quiet");
	chk_sync_exact: assert property (
		(!warm_rst_n && sync_clock_mode) [*5] |-> !clock_code_is_ceiling)
		else $error("sync mode left code as ceiling");
	chk_async_ceil: assert property (
		(!warm_rst_n && !sync_clock_mode) [*5] |-> clock_code_is_ceiling)
		else $error("async mode code not a ceiling");
	chk_stop_keeps_dw: assert property (
		(!link_stop_request_n && warm_rst_n) [*6] |->
		$stable({rx_dword_credit_active, tx_dword_credit_active}))
		else $error("link stop changed dword mode");

	cover property (acc && !mapped);
	cover property (!warm_rst_n [*5]);
	cover property (neg_done);
endmodule
bind link_width_freq_error_regs link_regs_asserts #(
	.REV_MAJ(REV_MAJ),
	.REV_MIN(REV_MIN),
	.RATE_CAP(RATE_CAP),
	.VENDOR_RATE(VENDOR_RATE)
) link_regs_asserts_i (.*);
`default_nettype wire

// ==== sim/testbench.sv ====
// self-checking bench for the link register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; \
	if ((g) !== (e)) begin num_errors++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end
module testbench;
	localparam int          CS  = 20;
	localparam int          CL  = 50;
	localparam logic [15:0] CAP = 16'h0023;
	int          num_errors = 0;
	int          checks_done = 0;
	logic [15:0] lf = 16'h001E;
	logic [31:0] q;
	logic        e;
	logic [2:0]  rxu = 3'h1, txu = 3'h1, lg = 3'h0;
	logic        rxo = 1'b0, txo = 1'b0, tmo = 1'b0;
	logic [3:0]  code = 4'h0;
	logic        core_clk = 1'b0, rst = 1'b1;
	logic        warm_rst_n = 1'b1, link_stop_request_n = 1'b1;
	logic        link_control_strobe = 1'b1, ctl_watch_en = 1'b0;
	logic        sync_clock_mode = 1'b0, neg_done = 1'b0;
	logic [2:0]  neg_rx_width = 3'h0, neg_tx_width = 3'h0;
	logic        proto_err_evt = 1'b0, overflow_evt = 1'b0;
	logic        tx_issue_evt = 1'b0, end_of_chain = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0]  pstrb = 4'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, clock_code_is_ceiling;
	logic [2:0]  rx_width_active, tx_width_active;
	logic        rx_dword_credit_active, tx_dword_credit_active;
	logic [3:0]  tx_clock_code_active, tx_lane_off;

	link_width_freq_error_regs #(
		.CTL_SHORT(CS),
		.CTL_LONG (CL)
	) link_width_freq_error_regs_i (.*);

	// free-running core clock
	always #5 core_clk = ~core_clk;

	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	function automatic logic ok_w(input logic [2:0] c);
		return c inside {3'h0, 3'h1, 3'h4, 3'h5, 3'h7};
	endfunction

	task automatic final_report;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// one apb transfer after an idle edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1)
		begin
			num_errors++;
			final_report();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0, 4'h0);
		`CHK("prdata", x, q)
	endtask

	// width byte write, model keeps illegal codes out
	task automatic cfg_wr(input logic [7:0] b, input logic [3:0] s);
		apb(1'b1, 8'h18, {16'h0, b, ~b}, s);
		if (s[1])
		begin
			rxo = b[3];
			txo = b[7];
			rxu = ok_w(b[2:0]) ? b[2:0] : rxu;
			txu = ok_w(b[6:4]) ? b[6:4] : txu;
		end
		rd(8'h18, {16'h0, txo, txu, rxo, rxu, 8'h99});
	endtask

	// clock code and fault byte write
	task automatic frq_wr(input logic [7:0] b);
		apb(1'b1, 8'h24, {24'h0, b}, 4'h1);
		code = CAP[b[3:0]] ? b[3:0] : code;
		lg = lg & ~b[6:4];
		tmo = b[7];
		rd(8'h24, {24'h0, tmo, lg, code});
	endtask

	task automatic pulse(input logic [4:0] v);
		@(posedge core_clk);
		{neg_done, proto_err_evt, overflow_evt, tx_issue_evt,
			end_of_chain} <= v;
		@(posedge core_clk);
		{neg_done, proto_err_evt, overflow_evt, tx_issue_evt} <= 4'h0;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	// main sequence
	initial
	begin
		cyc(2);
		rst <= 1'b0;
		rd(8'h18, 32'h1199);
		rd(8'h20, 32'h20);
		rd(8'h24, 32'h0);
		rd(8'h28, 32'h23);
		rd(8'h2C, 32'h30411);
		`CHK("lane_off", 4'hC, tx_lane_off)
		rd(8'h30, 32'h0);
		`CHK("pslverr", 1'b1, e)
		apb(1'b1, 8'h19, 32'hFFFF, 4'hF);
		`CHK("pslverr", 1'b1, e)
		// writes to a read-only register are ignored
		apb(1'b1, 8'h20, 32'hFFFF_FFFF, 4'hF);
		`CHK("pslverr", 1'b0, e)
		rd(8'h20, 32'h20);
		// first negotiation loads, a later one is ignored
		neg_tx_width <= 3'h4;
		pulse(5'h10);
		neg_rx_width <= 3'h5;
		neg_tx_width <= 3'h5;
		pulse(5'h10);
		rxu = 3'h0;
		txu = 3'h4;
		rd(8'h2C, 32'h110440);
		`CHK("lane_off", 4'hE, tx_lane_off)
		// reserved and too wide codes, then random widths
		for (int i = 0; i < 14; i++)
		begin
			lf = lfsr(lf);
			cfg_wr(i == 0 ? 8'h62 : i == 1 ? 8'h33 : lf[7:0],
				{2'h0, lf[8] | (i < 2), lf[9]});
			`CHK("tx_width", 3'h4, tx_width_active)
		end
		cfg_wr(8'h9D, 4'h2);
		link_stop_request_n <= 1'b0;
		cyc(7);
		`CHK("rx_width", 3'h5, rx_width_active)
		`CHK("rx_dword", 1'b0, rx_dword_credit_active)
		`CHK("lane_off", 4'hC, tx_lane_off)
		link_stop_request_n <= 1'b1;
		// every clock code, only capable ones stick
		for (int c = 0; c < 16; c++)
			frq_wr({4'h0, 4'(c)});
		frq_wr(8'h85);
		`CHK("code_act", 4'h0, tx_clock_code_active)
		sync_clock_mode <= 1'b1;
		warm_rst_n <= 1'b0;
		cyc(6);
		`CHK("code_act", 4'h5, tx_clock_code_active)
		`CHK("ceiling", 1'b0, clock_code_is_ceiling)
		`CHK("dword", 2'h3, {rx_dword_credit_active, tx_dword_credit_active})
		warm_rst_n <= 1'b1;
		sync_clock_mode <= 1'b0;
		cyc(4);
		tmo = 1'b0;
		rd(8'h24, 32'h05);
		// random fault events with write-one-to-clear
		for (int i = 0; i < 16; i++)
		begin
			lf = lfsr(lf);
			pulse({1'b0, lf[3:0]});
			lg = lg | {lf[1] & lf[0], lf[2], lf[3]};
			frq_wr({1'b0, lf[6:4], 4'h5});
		end
		// control strobe held low, short then long limit
		frq_wr(8'h75);
		ctl_watch_en <= 1'b1;
		link_control_strobe <= 1'b0;
		cyc(CS - 6);
		rd(8'h24, 32'h05);
		cyc(10);
		rd(8'h24, 32'h15);
		link_control_strobe <= 1'b1;
		frq_wr(8'h95);
		link_control_strobe <= 1'b0;
		cyc(CL - 26);
		rd(8'h24, 32'h85);
		cyc(30);
		rd(8'h24, 32'h95);
		// shorter limit chosen while already past it
		apb(1'b1, 8'h24, 32'h15, 4'h1);
		rd(8'h24, 32'h15);
		warm_rst_n <= 1'b0;
		cyc(6);
		`CHK("ceiling", 1'b1, clock_code_is_ceiling)
		warm_rst_n <= 1'b1;
		link_control_strobe <= 1'b1;
		// cold reset in mid-run
		rst <= 1'b1;
		cyc(2);
		rst <= 1'b0;
		rd(8'h18, 32'h1199);
		rd(8'h24, 32'h0);
		`CHK("rx_dword", 1'b0, rx_dword_credit_active)
		final_report();
	end
endmodule
`default_nettype wire
